// ==== hw/sps_prereg.sv ====
// Pre-regulator supply switch with debounce and hysteresis
`timescale 1ns/1ps
module sps_prereg (
   input  wire logic mclk_i,
   input  wire logic arst_n_i,
   input  wire logic monitor_en_i,
   input  wire logic below_off_i,
   input  wire logic above_on_i,
   input  wire logic burst_i,
   output logic      closed_o,
   output logic      uvlo_shift_o
);
   import sps_pkg::*;
   logic [10:0] cnt_q;
   logic        closed_q;
   logic        shift_q;

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_q <= 11'h000;
      end else if (!monitor_en_i || !below_off_i || !closed_q) begin
         cnt_q <= 11'h000;
      end else if (cnt_q != PREREG_CNT_LIMIT) begin
         cnt_q <= cnt_q + 11'h001;
      end
   end

   // Open needs more than the debounce count; burst opens at once
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         closed_q <= PREREG_RESET;
      end else if (monitor_en_i && burst_i) begin
         closed_q <= 1'b0;
      end else if (closed_q && monitor_en_i && below_off_i && cnt_q == PREREG_CNT_LIMIT) begin
         closed_q <= 1'b0;
      end else if (!closed_q && monitor_en_i && above_on_i) begin
         closed_q <= 1'b1;
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         shift_q <= 1'b0;
      end else begin
         shift_q <= monitor_en_i && below_off_i;
      end
   end

   assign closed_o     = closed_q;
   assign uvlo_shift_o = shift_q;

   prereg_debounce_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      (closed_q && $fell(closed_q) == 1'b0 && closed_q && !burst_i
       && cnt_q < PREREG_CNT_LIMIT) |=> closed_q || $past(burst_i))
      else $error("Switch opened before debounce elapsed");
   prereg_hyst_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      $rose(closed_q) |-> $past(above_on_i) && $past(monitor_en_i))
      else $error("Switch closed without rising above on threshold");
   uvlo_shift_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      (monitor_en_i && below_off_i) |=> shift_q)
      else $error("Undervoltage shift missing");
endmodule

// ==== hw/sps_sync.sv ====
// Two-stage synchroniser bank for analog comparator flags
`timescale 1ns/1ps
module sps_sync (
   input  wire logic        mclk_i,
   input  wire logic        arst_n_i,
   input  wire logic [13:0] raw_i,
   sps_flags_if.src         flags
);
   import sps_pkg::*;
   logic [13:0] s1_q;
   logic [13:0] s2_q;

   genvar g;
   generate
      for (g = 0; g < 14; g++) begin : g_bit
         always_ff @(posedge mclk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
               s1_q[g] <= SYNC_RESET[0];
               s2_q[g] <= SYNC_RESET[0];
            end else begin
               s1_q[g] <= raw_i[g];
               s2_q[g] <= s1_q[g];
            end
         end
      end
   endgenerate

   assign flags.severe_ocp        = s2_q[0];
   assign flags.comp_below_off    = s2_q[1];
   assign flags.comp_above_on     = s2_q[2];
   assign flags.comp_burst        = s2_q[3];
   assign flags.comp_sat_high     = s2_q[4];
   assign flags.comp_low_clamp    = s2_q[5];
   assign flags.disable_trip      = s2_q[6];
   assign flags.brownout          = s2_q[7];
   assign flags.ss_at_clamp       = s2_q[8];
   assign flags.ss_at_disable     = s2_q[9];
   assign flags.ss_at_latch       = s2_q[10];
   assign flags.switch_thermal    = s2_q[11];
   assign flags.vcc_below_startup = s2_q[12];
   assign flags.vcc_below_band    = s2_q[13];
endmodule

// ==== hw/sps_top.sv ====
// Protection and supervision sequencer for an offline power controller
// ------------------------------------------------------------
// Behaviour
// ------------------------------------------------------------
// Behaviour
// - Watch the severe overcurrent comparator, set well above normal limit.
// - First severe trip moves idle to warning without stopping.
// - Warning returns idle on a clean cycle, stops on a second trip.
// - Stop may occasionally follow a third detection instead of the second.
// - Overcurrent stop stays latched until undervoltage lockout clears it.
// - Pre-regulator switch closed by default, opens below mode-dependent threshold.
// - Opens only after over 1024 cycles below; burst opens immediately.
// - Once open, closes only above the higher re-enable threshold.
// - Below off threshold, lower undervoltage lockout threshold by 2.4 V.
// - Stop when the pre-regulator switch thermal protection trips.
// - Disable input above reference shuts down at once, low consumption.
// - Disable shutdown latched, cleared only by undervoltage lockout.
// - Latched off, toggle startup generator between startup and 0.5 V below.
// - Brownout during latch-off stops generator until restart level clears latch.
// - At start-up charge soft-start with primary current, clamp at 2 V.
// - Overcurrent setpoint ramps from zero to feedforward value during ramp.
// - Control voltage monitors disabled until soft-start reaches clamp.
// - Control saturated high removes clamp, charges with quarter current.
// - Soft-start at 5 V disables device; two drops higher latches off.
// - Overload ending before 5 V stops second current, returns to clamp.
// - Grounded soft-start is not relied on to disable the gate driver.
// - Force feedforward input to ground in lockout, latch or low clamp.
// ------------------------------------------------------------
`timescale 1ns/1ps
module sps_top (
   input  wire logic mclk_i,
   input  wire logic arst_n_i,
   input  wire logic osc_cycle_i,
   input  wire logic severe_ocp_i,
   input  wire logic comp_below_off_i,
   input  wire logic comp_above_on_i,
   input  wire logic comp_burst_i,
   input  wire logic comp_sat_high_i,
   input  wire logic comp_low_clamp_i,
   input  wire logic latched_disable_in_i,
   input  wire logic brownout_sense_in_i,
   input  wire logic ss_at_clamp_i,
   input  wire logic ss_at_disable_i,
   input  wire logic ss_at_latch_i,
   input  wire logic switch_thermal_i,
   input  wire logic vcc_below_startup_i,
   input  wire logic vcc_below_band_i,
   output logic      run_o,
   output logic      low_power_o,
   output logic      latched_off_o,
   output logic      preregulator_supply_out_o,
   output logic      uvlo_shift_o,
   output logic      startup_gen_on_o,
   output logic      softstart_current_primary_o,
   output logic      softstart_current_overload_o,
   output logic      softstart_clamp_o,
   output logic      softstart_ramping_o,
   output logic      line_feedforward_in_ground_o
);
   import sps_pkg::*;

   // ------------------------------------------------------------
   // Synchronised flags
   // ------------------------------------------------------------
   sps_flags_if fl ();

   sps_sync u_sync (
      .mclk_i   (mclk_i),
      .arst_n_i (arst_n_i),
      .raw_i    ({vcc_below_band_i, vcc_below_startup_i, switch_thermal_i,
                  ss_at_latch_i, ss_at_disable_i, ss_at_clamp_i, brownout_sense_in_i,
                  latched_disable_in_i, comp_low_clamp_i, comp_sat_high_i,
                  comp_burst_i, comp_above_on_i, comp_below_off_i, severe_ocp_i}),
      .flags    (fl)
   );

   // ------------------------------------------------------------
   // Severe overcurrent hiccup logic
   // ------------------------------------------------------------
   // A trip is remembered until the next oscillator cycle boundary, so a
   // trip near the boundary is judged one cycle later: the third-detection case.
   sps_ocp_state_t ocp_q;
   logic           trip_seen_q;
   logic           ocp_stop;

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         trip_seen_q <= 1'b0;
      end else if (osc_cycle_i) begin
         trip_seen_q <= fl.severe_ocp;
      end else if (fl.severe_ocp) begin
         trip_seen_q <= 1'b1;
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ocp_q <= OCP_IDLE;
      end else if (osc_cycle_i) begin
         case (ocp_q)
            OCP_IDLE: begin
               if (trip_seen_q) begin
                  ocp_q <= OCP_WARN;
               end
            end
            OCP_WARN: begin
               ocp_q <= trip_seen_q ? OCP_STOP : OCP_IDLE;
            end
            OCP_STOP: begin
               ocp_q <= OCP_STOP;
            end
            default: begin
               ocp_q <= OCP_IDLE;
            end
         endcase
      end
   end
   assign ocp_stop = (ocp_q == OCP_STOP);

   // ------------------------------------------------------------
   // Latched disable and thermal stop
   // ------------------------------------------------------------
   // Only undervoltage lockout (arst_n_i) clears these latches.
   logic dis_latch_q;
   logic therm_stop_q;
   logic ss_latch_q;
   logic any_latch;

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         dis_latch_q <= 1'b0;
      end else if (fl.disable_trip) begin
         dis_latch_q <= 1'b1;
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         therm_stop_q <= 1'b0;
      end else if (fl.switch_thermal) begin
         therm_stop_q <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Soft-start sequencing
   // ------------------------------------------------------------
   sps_ss_state_t ss_q;
   logic          monitor_en;

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ss_q <= SS_RAMP;
      end else begin
         case (ss_q)
            SS_RAMP: begin
               if (fl.ss_at_clamp) begin
                  ss_q <= SS_CLAMP;
               end
            end
            SS_CLAMP: begin
               if (fl.comp_sat_high) begin
                  ss_q <= SS_OVLD;
               end
            end
            SS_OVLD: begin
               if (!fl.comp_sat_high && !fl.ss_at_disable) begin
                  ss_q <= SS_DRAIN;
               end
            end
            SS_DRAIN: begin
               if (fl.comp_sat_high) begin
                  ss_q <= SS_OVLD;
               end else if (fl.ss_at_clamp) begin
                  ss_q <= SS_CLAMP;
               end
            end
            default: begin
               ss_q <= SS_RAMP;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ss_latch_q <= 1'b0;
      end else if (fl.ss_at_latch) begin
         ss_latch_q <= 1'b1;
      end
   end

   assign monitor_en = (ss_q != SS_RAMP);
   assign any_latch  = ocp_stop || dis_latch_q || therm_stop_q || ss_latch_q;

   // ------------------------------------------------------------
   // Pre-regulator switch
   // ------------------------------------------------------------
   logic prereg_closed;
   logic uvlo_shift;

   sps_prereg u_prereg (
      .mclk_i       (mclk_i),
      .arst_n_i     (arst_n_i),
      .monitor_en_i (monitor_en),
      .below_off_i  (fl.comp_below_off),
      .above_on_i   (fl.comp_above_on),
      .burst_i      (fl.comp_burst),
      .closed_o     (prereg_closed),
      .uvlo_shift_o (uvlo_shift)
   );

   // ------------------------------------------------------------
   // Startup generator while latched off
   // ------------------------------------------------------------
   logic hv_on_q;
   logic bo_hold_q;

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         bo_hold_q <= 1'b0;
      end else if (any_latch && fl.brownout) begin
         bo_hold_q <= 1'b1;
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         hv_on_q <= 1'b0;
      end else if (!any_latch || bo_hold_q || (any_latch && fl.brownout)) begin
         hv_on_q <= 1'b0;
      end else if (fl.vcc_below_band) begin
         hv_on_q <= 1'b1;
      end else if (!fl.vcc_below_startup) begin
         hv_on_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Outputs (all but latched_off_o from flip-flops)
   // ------------------------------------------------------------
   // Run is gated here, not by soft-start level alone: a grounded
   // soft-start pin does not stop switching.
   logic run_q;
   logic lowp_q;
   logic ffg_q;
   logic pri_q;
   logic ovl_q;
   logic clamp_q;
   logic ramp_q;
   logic pre_q;

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         run_q   <= 1'b0;
         lowp_q  <= 1'b0;
         ffg_q   <= 1'b1;
         pri_q   <= 1'b0;
         ovl_q   <= 1'b0;
         clamp_q <= 1'b0;
         ramp_q  <= 1'b0;
         pre_q   <= PREREG_RESET;
      end else begin
         run_q   <= !any_latch && !fl.disable_trip && !fl.ss_at_disable
                    && !(ocp_q == OCP_WARN && trip_seen_q && osc_cycle_i);
         lowp_q  <= dis_latch_q || fl.disable_trip;
         ffg_q   <= any_latch || (monitor_en && fl.comp_low_clamp);
         pri_q   <= (ss_q == SS_RAMP) || (ss_q == SS_CLAMP);
         ovl_q   <= (ss_q == SS_OVLD);
         clamp_q <= (ss_q != SS_OVLD);
         ramp_q  <= (ss_q == SS_RAMP);
         pre_q   <= prereg_closed && !any_latch;
      end
   end

   assign run_o                        = run_q;
   assign low_power_o                  = lowp_q;
   assign latched_off_o                = any_latch;
   assign preregulator_supply_out_o    = pre_q;
   assign uvlo_shift_o                 = uvlo_shift;
   assign startup_gen_on_o             = hv_on_q;
   assign softstart_current_primary_o  = pri_q;
   assign softstart_current_overload_o = ovl_q;
   assign softstart_clamp_o            = clamp_q;
   assign softstart_ramping_o          = ramp_q;
   assign line_feedforward_in_ground_o = ffg_q;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence warn_then_trip;
      (osc_cycle_i && ocp_q == OCP_WARN && trip_seen_q);
   endsequence

   sequence warn_then_clean;
      (osc_cycle_i && ocp_q == OCP_WARN && !trip_seen_q);
   endsequence

   ocp_stop_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      warn_then_trip |=> ocp_stop ##1 !run_o)
      else $error("Second trip did not stop device");
   ocp_clear_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      warn_then_clean |=> ocp_q == OCP_IDLE)
      else $error("Clean cycle did not return to idle");
   ocp_warn_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      (osc_cycle_i && ocp_q == OCP_IDLE && trip_seen_q) |=> ocp_q == OCP_WARN)
      else $error("First trip did not enter warning");
   ocp_hold_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      ocp_stop |=> ocp_stop)
      else $error("Overcurrent stop released while supplied");
   run_latch_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      any_latch |=> !run_o)
      else $error("Device ran while latched off");
   dis_shut_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      fl.disable_trip |=> !run_o && low_power_o ##1 latched_off_o)
      else $error("Disable did not shut down");
   dis_hold_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      dis_latch_q |=> latched_off_o && low_power_o)
      else $error("Disable latch released while supplied");
   monitor_gate_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      (ss_q == SS_RAMP) |-> !monitor_en ##1 !uvlo_shift)
      else $error("Monitor active during soft-start ramp");
   ss_ramp_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      (ss_q == SS_RAMP) |=> softstart_current_primary_o && softstart_ramping_o)
      else $error("Primary current missing during ramp");
   ss_ovld_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      (ss_q == SS_CLAMP && fl.comp_sat_high) |=> ##1 ovl_q && !clamp_q)
      else $error("Overload current not applied");
   ss_drain_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      (ss_q == SS_DRAIN) |=> !softstart_current_overload_o && softstart_clamp_o)
      else $error("Overload current kept after overload ended");
   hv_band_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      (any_latch && !bo_hold_q && !fl.brownout && fl.vcc_below_band) |=> startup_gen_on_o)
      else $error("Startup generator not restarted below band");
   hv_idle_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      !any_latch |=> !startup_gen_on_o)
      else $error("Startup generator on while not latched");
   hv_bo_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      (any_latch && fl.brownout) |=> !hv_on_q [*3])
      else $error("Startup generator ran after brownout");
   ffg_latch_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      any_latch |=> line_feedforward_in_ground_o)
      else $error("Feedforward not grounded under latch");
   ffg_low_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      (monitor_en && fl.comp_low_clamp) |=> line_feedforward_in_ground_o)
      else $error("Feedforward not grounded at low clamp");
endmodule

// ==== include/sps_flags_if.sv ====
// Interface: synchronised comparator flags
`timescale 1ns/1ps
interface sps_flags_if;
   logic severe_ocp;
   logic comp_below_off;
   logic comp_above_on;
   logic comp_burst;
   logic comp_sat_high;
   logic comp_low_clamp;
   logic disable_trip;
   logic brownout;
   logic ss_at_clamp;
   logic ss_at_disable;
   logic ss_at_latch;
   logic switch_thermal;
   logic vcc_below_startup;
   logic vcc_below_band;
   modport src (output severe_ocp, comp_below_off, comp_above_on, comp_burst,
                comp_sat_high, comp_low_clamp, disable_trip, brownout, ss_at_clamp,
                ss_at_disable, ss_at_latch, switch_thermal, vcc_below_startup,
                vcc_below_band);
   modport dst (input severe_ocp, comp_below_off, comp_above_on, comp_burst,
                comp_sat_high, comp_low_clamp, disable_trip, brownout, ss_at_clamp,
                ss_at_disable, ss_at_latch, switch_thermal, vcc_below_startup,
                vcc_below_band);
endinterface

// ==== include/sps_pkg.sv ====
// Package: constants and types for the protection sequencer
package sps_pkg;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS      = 4;
   localparam int unsigned PREREG_OFF_CYCLES  = 1024;
   localparam logic [10:0] PREREG_CNT_LIMIT   = 11'(PREREG_OFF_CYCLES);
   // Adaptive undervoltage shift, in millivolts
   localparam int unsigned UVLO_SHIFT_MV      = 2400;
   // Startup hysteresis band while latched off, in millivolts
   localparam int unsigned STARTUP_BAND_MV    = 500;
   // Reset values
   localparam logic        PREREG_RESET       = 1'b1;
   localparam logic [1:0]  SYNC_RESET         = 2'h0;

   // ------------------------------------------------------------
   // States
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      OCP_IDLE = 3'b001,
      OCP_WARN = 3'b010,
      OCP_STOP = 3'b100
   } sps_ocp_state_t;

   typedef enum logic [3:0] {
      SS_RAMP  = 4'b0001,
      SS_CLAMP = 4'b0010,
      SS_OVLD  = 4'b0100,
      SS_DRAIN = 4'b1000
   } sps_ss_state_t;
endpackage

// ==== test/sps_ss_cap.sv ====
// Soft-start capacitor model at the far side of the sequencer
`timescale 1ns/1ps
module sps_ss_cap #(
   parameter int CLAMP_LVL = 40,
   parameter int DIS_LVL   = 100,
   parameter int LATCH_LVL = 110
) (
   input  wire logic mclk_i,
   input  wire logic arst_n_i,
   input  wire logic prim_i,
   input  wire logic ovld_i,
   input  wire logic clamp_i,
   output logic      at_clamp_o,
   output logic      at_disable_o,
   output logic      at_latch_o
);
   int lvl_q;

   // ------------------------------------------------------------
   // Charge and discharge
   // ------------------------------------------------------------
   // Reset models a fully discharged capacitor
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         lvl_q <= 0;
      end else if (ovld_i) begin
         lvl_q <= lvl_q + 1;
      end else if (prim_i && (!clamp_i || lvl_q < CLAMP_LVL)) begin
         lvl_q <= lvl_q + 4;
      end else if (lvl_q > CLAMP_LVL) begin
         lvl_q <= lvl_q - 1;
      end
   end

   assign at_clamp_o   = lvl_q >= CLAMP_LVL;
   assign at_disable_o = lvl_q >= DIS_LVL;
   assign at_latch_o   = lvl_q >= LATCH_LVL;
endmodule

// ==== test/tb_sps_top.sv ====
// Self-checking testbench for the protection sequencer
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin failures++; \
   $display("BAD %s exp %b got %b", nm, exp, got); end end
module tb_sps_top;
   import sps_pkg::*;
   logic mclk_i, arst_n_i, osc, sev, blw, abv, bst, sat, lowc, dis, bro, thm, vst, vbd;
   logic run, lp, lat, pre, shf, gen, prim, ovl, clp, rmp, gnd, at_c, at_d, at_l;
   int   failures = 0;
   int   checked = 0;

   sps_top dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .osc_cycle_i(osc), .severe_ocp_i(sev),
      .comp_below_off_i(blw), .comp_above_on_i(abv), .comp_burst_i(bst),
      .comp_sat_high_i(sat), .comp_low_clamp_i(lowc), .latched_disable_in_i(dis),
      .brownout_sense_in_i(bro), .ss_at_clamp_i(at_c), .ss_at_disable_i(at_d),
      .ss_at_latch_i(at_l), .switch_thermal_i(thm), .vcc_below_startup_i(vst),
      .vcc_below_band_i(vbd), .run_o(run), .low_power_o(lp), .latched_off_o(lat),
      .preregulator_supply_out_o(pre), .uvlo_shift_o(shf), .startup_gen_on_o(gen),
      .softstart_current_primary_o(prim), .softstart_current_overload_o(ovl),
      .softstart_clamp_o(clp), .softstart_ramping_o(rmp), .line_feedforward_in_ground_o(gnd));

   sps_ss_cap cap (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .prim_i(prim), .ovld_i(ovl),
      .clamp_i(clp), .at_clamp_o(at_c), .at_disable_o(at_d), .at_latch_o(at_l));

   initial begin
      mclk_i = 1'b0;
      forever #2 mclk_i = ~mclk_i;
   end

   task automatic cyc(input int n);
      repeat (n) @(negedge mclk_i);
   endtask

   task automatic osc_pulse();
      osc = 1'b1;
      cyc(1);
      osc = 1'b0;
      cyc(3);
   endtask

   // Reset checks outputs mid-reset, then waits out the soft-start ramp
   task automatic do_reset();
      {osc, sev, blw, abv, bst, sat, lowc, dis, bro, thm, vst, vbd} = 12'h000;
      arst_n_i = 1'b0;
      cyc(5);
      `CHK("pre_rst", PREREG_RESET, pre)
      `CHK("gnd_rst", 1'b1, gnd)
      arst_n_i = 1'b1;
      cyc(3);
      `CHK("prim_on", 1'b1, prim)
      `CHK("ramping", 1'b1, rmp)
      cyc(30);
      `CHK("ramp_end", 1'b0, rmp)
      `CHK("run_ok", 1'b1, run)
   endtask

   // A trip that clears before the boundary only warns; one that lasts
   // into the next switching cycle stops the device
   task automatic t_ocp();
      sev = 1'b1;
      cyc(3);
      sev = 1'b0;
      cyc(3);
      osc_pulse();
      `CHK("warn_run", 1'b1, run)
      `CHK("warn_lat", 1'b0, lat)
      osc_pulse();
      osc_pulse();
      `CHK("idle_run", 1'b1, run)
      sev = 1'b1;
      cyc(3);
      osc_pulse();
      `CHK("rewarn_run", 1'b1, run)
      repeat (2) osc_pulse();
      sev = 1'b0;
      `CHK("stop_run", 1'b0, run)
      `CHK("stop_lat", 1'b1, lat)
      `CHK("stop_gnd", 1'b1, gnd)
      cyc(50);
      `CHK("stop_hold", 1'b1, lat)
      do_reset();
      `CHK("stop_clr", 1'b0, lat)
   endtask

   task automatic t_prereg();
      // Two synchroniser stages come on top of the debounce count
      blw = 1'b1;
      cyc(int'(PREREG_OFF_CYCLES) + 2);
      `CHK("pre_wait", 1'b1, pre)
      `CHK("uvlo_shf", 1'b1, shf)
      cyc(2);
      `CHK("pre_open", 1'b0, pre)
      blw = 1'b0;
      cyc(10);
      `CHK("pre_hyst", 1'b0, pre)
      abv = 1'b1;
      cyc(6);
      `CHK("pre_close", 1'b1, pre)
      abv = 1'b0;
      bst = 1'b1;
      cyc(6);
      `CHK("pre_burst", 1'b0, pre)
      bst = 1'b0;
      lowc = 1'b1;
      cyc(6);
      `CHK("gnd_low", 1'b1, gnd)
      do_reset();
   endtask

   task automatic t_disable();
      dis = 1'b1;
      cyc(6);
      dis = 1'b0;
      `CHK("dis_run", 1'b0, run)
      `CHK("dis_lp", 1'b1, lp)
      {vst, vbd} = 2'h3;
      cyc(6);
      `CHK("gen_on", 1'b1, gen)
      vbd = 1'b0;
      cyc(6);
      `CHK("gen_hyst", 1'b1, gen)
      vst = 1'b0;
      cyc(6);
      `CHK("gen_off", 1'b0, gen)
      `CHK("dis_held", 1'b1, lp)
      bro = 1'b1;
      {vst, vbd} = 2'h3;
      cyc(6);
      `CHK("gen_bro", 1'b0, gen)
      bro = 1'b0;
      cyc(6);
      `CHK("gen_bro_hold", 1'b0, gen)
      do_reset();
      `CHK("dis_clr", 1'b0, lp)
   endtask

   task automatic t_overload();
      sat = 1'b1;
      cyc(20);
      `CHK("ovl_on", 1'b1, ovl)
      `CHK("clamp_off", 1'b0, clp)
      sat = 1'b0;
      cyc(10);
      `CHK("ovl_end", 1'b0, ovl)
      `CHK("ovl_run", 1'b1, run)
      sat = 1'b1;
      cyc(60);
      `CHK("ovl_dis", 1'b0, run)
      `CHK("ovl_nolat", 1'b0, lat)
      cyc(30);
      `CHK("ovl_stop", 1'b0, run)
      `CHK("ovl_lat", 1'b1, lat)
      do_reset();
      thm = 1'b1;
      cyc(6);
      `CHK("thm_lat", 1'b1, lat)
      `CHK("thm_run", 1'b0, run)
   endtask

   task automatic report_and_stop();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      do_reset();
      t_ocp();
      t_prereg();
      t_disable();
      t_overload();
      report_and_stop();
   end

   // Whole run needs about 1500 cycles; over thirteen times that means a hang
   initial begin
      repeat (20000) @(posedge mclk_i);
      failures++;
      report_and_stop();
   end
endmodule
